// *** core/pcr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcr_map.svh"

module pcr_regs (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic global_reset_n,
   input wire pcr_pkg::pcr_cfg_req_t cfg_req,
   output var pcr_pkg::pcr_cfg_rsp_t cfg_rsp,
   input wire logic eeprom_load,
   input wire logic [7:0] eeprom_phy_bits,
   input wire logic cable_not_active,
   input wire logic link_power_status,
   output logic cable_activity_out,
   output logic phy_reset_ctl,
   output logic phy_powerdown_ctl,
   output logic ultra_low_power
);
   import pcr_pkg::*;

   logic [7:0] phy_ctl_reg;
   logic [7:0] phy_ctl_next;
   logic [15:0] misc_reg;
   logic [15:0] misc_next;
   pcr_cfg_rsp_t rsp_next;
   logic [1:0] pins_sync;
   wire logic cable_not_active_s;
   wire logic link_power_s;

   // The PHY pins arrive from another block of logic, so retime them first
   pcr_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in({link_power_status, cable_not_active}),
      .pin_out(pins_sync)
   );
   assign cable_not_active_s = pins_sync[0];
   assign link_power_s = pins_sync[1];

   // Decode; accesses are refused while the function reset is held
   wire logic hit_phy = {cfg_req.addr[7:2], 2'b00} == `PCR_PHY_CTL_OFF;
   wire logic hit_misc = {cfg_req.addr[7:2], 2'b00} == `PCR_MISC_CFG_OFF;
   wire logic wr_ok = cfg_req.wr & rst_n;
   wire logic rd_ok = cfg_req.rd & rst_n & ~cfg_req.wr;
   wire logic phy_wr = wr_ok & hit_phy & cfg_req.be[0];
   wire logic misc_wr = wr_ok & hit_misc & (cfg_req.be[0] | cfg_req.be[1]);

   // Byte 0 is the only lane the PHY control register owns
   wire logic [7:0] phy_wmask = `PCR_PHY_CTL_WR_MASK; // RULE1 RULE4 RULE13
   wire logic [7:0] phy_ee_mask = `PCR_PHY_CTL_EE_MASK;
   wire logic [7:0] phy_after_wr = phy_wr ?
      ((phy_ctl_reg & ~phy_wmask) | (cfg_req.wdata[7:0] & phy_wmask)) : phy_ctl_reg;

   // An EEPROM load in the same cycle as a write wins on the loaded bits
   assign phy_ctl_next = eeprom_load ?
      ((phy_after_wr & ~phy_ee_mask) | (eeprom_phy_bits & phy_ee_mask)) // RULE3 RULE6 RULE10
      : phy_after_wr;

   wire logic [15:0] misc_lanes = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
   wire logic [15:0] misc_wmask = misc_lanes & `PCR_MISC_CFG_WR_MASK; // RULE13
   assign misc_next = misc_wr ?
      ((misc_reg & ~misc_wmask) | (cfg_req.wdata[15:0] & misc_wmask)) : misc_reg;

   // Bits 1 and 0 are held for the EEPROM but always read back as zero
   wire logic [31:0] phy_rd_word = // RULE1 RULE4 RULE10
      {24'h000000, phy_ctl_reg & `PCR_PHY_CTL_RD_MASK};
   wire logic [31:0] misc_rd_word = {16'h0000, misc_reg}; // RULE12
   wire logic [31:0] rd_word = hit_phy ? phy_rd_word : (hit_misc ? misc_rd_word : 32'h00000000);

   always_comb begin
      rsp_next.ack = wr_ok | rd_ok;
      rsp_next.rdata = rd_ok ? rd_word : 32'h00000000;
   end

   // Only the global reset touches this register, so a function reset keeps the PHY alive
   always_ff @(posedge clk_sys) begin
      if (!global_reset_n) begin
         phy_ctl_reg <= `PCR_PHY_CTL_RST; // RULE11 RULE5 RULE6 RULE7
      end else begin
         phy_ctl_reg <= phy_ctl_next;
      end
   end

   // Unmarked misc bits return to default on the function reset as well
   always_ff @(posedge clk_sys) begin
      if (!global_reset_n) begin
         misc_reg <= `PCR_MISC_CFG_RST; // RULE12
      end else if (!rst_n) begin
         misc_reg <= (misc_reg & `PCR_MISC_CFG_GLOBAL_MASK) |
                     (`PCR_MISC_CFG_RST & ~`PCR_MISC_CFG_GLOBAL_MASK);
      end else begin
         misc_reg <= misc_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_rsp <= '0;
      end else begin
         cfg_rsp <= rsp_next;
      end
   end

   // PHY controls; software must pulse reset after leaving power-down
   always_ff @(posedge clk_sys) begin
      if (!global_reset_n) begin
         cable_activity_out <= 1'b0;
         phy_reset_ctl <= 1'b0;
         phy_powerdown_ctl <= 1'b0;
         ultra_low_power <= 1'b0;
      end else begin
         cable_activity_out <= phy_ctl_reg[`PCR_PHY_ROUTE_BIT] & cable_not_active_s; // RULE2
         phy_reset_ctl <= phy_ctl_reg[`PCR_PHY_RESET_BIT]; // RULE5 RULE9
         phy_powerdown_ctl <= phy_ctl_reg[`PCR_PHY_PDOWN_BIT]; // RULE7
         ultra_low_power <= phy_ctl_reg[`PCR_PHY_PDOWN_BIT] & ~link_power_s; // RULE8
      end
   end

   property p_phy_hi_zero;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (cfg_req.rd && !cfg_req.wr && hit_phy) |=> (cfg_rsp.ack && cfg_rsp.rdata[31:8] == 24'h000000);
   endproperty
   a_phy_hi_zero: assert property (p_phy_hi_zero) else $error("phy upper bits not zero"); // RULE1

   property p_route;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (phy_ctl_reg[7] && cable_not_active_s) |=> cable_activity_out;
   endproperty
   a_route: assert property (p_route) else $error("cable activity not routed"); // RULE2

   property p_route_off;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      !phy_ctl_reg[7] |=> !cable_activity_out;
   endproperty
   a_route_off: assert property (p_route_off) else $error("routed while off"); // RULE2

   property p_ee_load;
      @(posedge clk_sys) disable iff (!global_reset_n)
      (eeprom_load && global_reset_n) |=>
         ((phy_ctl_reg & 8'h8B) == ($past(eeprom_phy_bits) & 8'h8B));
   endproperty
   a_ee_load: assert property (p_ee_load) else $error("eeprom load not applied"); // RULE3

   property p_rsvd_rd;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (cfg_req.rd && !cfg_req.wr && hit_phy) |=> (cfg_rsp.rdata[6:5] == 2'b00);
   endproperty
   a_rsvd_rd: assert property (p_rsvd_rd) else $error("bits 6:5 read nonzero"); // RULE4

   property p_low_rd;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (cfg_req.rd && !cfg_req.wr && hit_phy) |=> (cfg_rsp.rdata[1:0] == 2'b00);
   endproperty
   a_low_rd: assert property (p_low_rd) else $error("bits 1:0 read nonzero"); // RULE10

   property p_phy_rst;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (phy_wr && !eeprom_load) |=> ##1 (phy_reset_ctl == $past(cfg_req.wdata[4], 2));
   endproperty
   a_phy_rst: assert property (p_phy_rst) else $error("phy reset does not follow bit 4"); // RULE5

   property p_glb_val;
      @(posedge clk_sys) disable iff (!rst_n)
      !global_reset_n |=> (phy_ctl_reg == 8'h08 && misc_reg == 16'h0810);
   endproperty
   a_glb_val: assert property (p_glb_val) else $error("wrong global reset value"); // RULE6

   property p_glb_outs;
      @(posedge clk_sys) disable iff (!rst_n)
      !global_reset_n |=> (!phy_reset_ctl && !phy_powerdown_ctl &&
         !ultra_low_power && !cable_activity_out);
   endproperty
   a_glb_outs: assert property (p_glb_outs) else $error("phy outputs not cleared"); // RULE5 RULE7

   property p_pdown;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (phy_wr && !eeprom_load) |=> ##1 (phy_powerdown_ctl == $past(cfg_req.wdata[2], 2));
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down does not follow bit 2"); // RULE7

   property p_low_power;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      1'b1 |=> (ultra_low_power == ($past(phy_ctl_reg[2]) && !$past(link_power_s)));
   endproperty
   a_low_power: assert property (p_low_power) else $error("ultra-low-power mismatch"); // RULE8

   property p_func_rst_keep;
      @(posedge clk_sys) disable iff (!global_reset_n)
      (!rst_n && !eeprom_load) |=> $stable(phy_ctl_reg);
   endproperty
   a_func_rst_keep: assert property (p_func_rst_keep) else $error("function reset hit"); // RULE11

   property p_misc_ro;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      misc_wr |=> ((misc_reg & 16'h50E0) == 16'h0000);
   endproperty
   a_misc_ro: assert property (p_misc_ro) else $error("misc read-only bit set"); // RULE13 RULE12

   property p_rsvd_keep;
      @(posedge clk_sys) disable iff (!global_reset_n)
      1'b1 |-> (phy_ctl_reg[6:5] == 2'b00);
   endproperty
   a_rsvd_keep: assert property (p_rsvd_keep) else $error("bits 6:5 stored nonzero"); // RULE4

   property p_route_wr;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (phy_wr && !eeprom_load) |=> (phy_ctl_reg[7] == $past(cfg_req.wdata[7]));
   endproperty
   a_route_wr: assert property (p_route_wr) else $error("route bit not written"); // RULE2

   property p_misc_hi;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (cfg_req.rd && !cfg_req.wr && hit_misc) |=>
         (cfg_rsp.ack && cfg_rsp.rdata[31:16] == 16'h0000);
   endproperty
   a_misc_hi: assert property (p_misc_hi) else $error("misc upper half not zero"); // RULE12

   property p_misc_wr;
      @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (misc_wr && cfg_req.be[0]) |=> (misc_reg[4:0] == $past(cfg_req.wdata[4:0]));
   endproperty
   a_misc_wr: assert property (p_misc_wr) else $error("misc low bits not written"); // RULE12

   property p_misc_fn_rst;
      @(posedge clk_sys) disable iff (!global_reset_n)
      !rst_n |=> ((misc_reg & 16'h2007) == 16'h0000);
   endproperty
   a_misc_fn_rst: assert property (p_misc_fn_rst) else $error("misc reset bits set"); // RULE12

endmodule

`default_nettype wire

// *** core/pcr_map.svh ***
// Functional notes
// RULE1: PHY control bits 31 to 8 read zero and ignore writes.
// RULE2: Bit 7 set routes the PHY cable-not-active indication to its output pin.
// RULE3: An EEPROM load writes bit 7; it must be 1 for normal operation.
// RULE4: PHY control bits 6 and 5 read zero; software keeps them zero.
// RULE5: Bit 4 drives the PHY reset input; defaults 0, normally 0.
// RULE6: Bit 3 resets to 1, is EEPROM loadable, and stays 1 normally.
// RULE7: Bit 2 drives the PHY power-down input; defaults 0.
// RULE8: Power-down set with link power status off selects ultra-low-power mode.
// RULE9: After power-down is set then cleared, software pulses bit 4.
// RULE10: Bits 1 and 0 read zero, are EEPROM loadable, kept zero.
// RULE11: Marked PHY control bits are cleared only by the global reset.
// RULE12: Misc configuration register at F0h resets to 0000 0810h, upper half zero.
// RULE13: Writes to read-only bit positions are ignored in both registers.
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

`define PCR_PHY_CTL_OFF 8'hEC
`define PCR_MISC_CFG_OFF 8'hF0

`define PCR_PHY_CTL_RST 8'h08
`define PCR_PHY_CTL_WR_MASK 8'h9F
`define PCR_PHY_CTL_RD_MASK 8'h9C
`define PCR_PHY_CTL_EE_MASK 8'h8B

`define PCR_PHY_ROUTE_BIT 7
`define PCR_PHY_RESET_BIT 4
`define PCR_PHY_COMPLY_BIT 3
`define PCR_PHY_PDOWN_BIT 2

`define PCR_MISC_CFG_RST 16'h0810
`define PCR_MISC_CFG_WR_MASK 16'hAF1F
`define PCR_MISC_CFG_GLOBAL_MASK 16'h8F18

`endif

// *** core/pcr_pkg.sv ***
package pcr_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } pcr_cfg_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } pcr_cfg_rsp_t;

endpackage

// *** core/pcr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module pcr_sync (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [1:0] pin_in,
   output logic [1:0] pin_out
);
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_bit
         logic meta_reg;
         logic hold_reg;
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               meta_reg <= 1'b0;
               hold_reg <= 1'b0;
            end else begin
               meta_reg <= pin_in[i];
               hold_reg <= meta_reg;
            end
         end
         assign pin_out[i] = hold_reg;
      end
   endgenerate
endmodule

`default_nettype wire

// *** dv/pcr_phy_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcr_phy_model (
   input wire logic cable_idle_set,
   input wire logic phy_reset_ctl,
   input wire logic phy_powerdown_ctl,
   output logic cable_not_active
);
   // A PHY held in reset or power-down never reports cable activity
   assign cable_not_active = cable_idle_set | phy_reset_ctl | phy_powerdown_ctl;
endmodule
`default_nettype wire

// *** dv/phy_control_config_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module phy_control_config_regs_tb;
   import pcr_pkg::*;
   logic clk_sys = 0, rst_n = 0, global_reset_n = 0, eeprom_load = 0;
   logic cable_idle_set = 0, link_power_status = 0, cable_not_active;
   logic [7:0] eeprom_phy_bits = 8'h00, phy_m, a;
   logic [15:0] misc_m;
   logic [31:0] r, d;
   pcr_cfg_req_t cfg_req = '0;
   pcr_cfg_rsp_t cfg_rsp;
   logic cable_activity_out, phy_reset_ctl, phy_powerdown_ctl, ultra_low_power;
   int errors = 0, total_checks = 0, cycles = 0, seed = 32'h0f00e5b3, i;
   always #20 clk_sys = ~clk_sys;
   pcr_regs pcr_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .global_reset_n(global_reset_n),
      .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .eeprom_load(eeprom_load),
      .eeprom_phy_bits(eeprom_phy_bits), .cable_not_active(cable_not_active),
      .link_power_status(link_power_status), .cable_activity_out(cable_activity_out),
      .phy_reset_ctl(phy_reset_ctl), .phy_powerdown_ctl(phy_powerdown_ctl),
      .ultra_low_power(ultra_low_power));
   pcr_phy_model pcr_phy_model_inst (.cable_idle_set(cable_idle_set),
      .phy_reset_ctl(phy_reset_ctl), .phy_powerdown_ctl(phy_powerdown_ctl),
      .cable_not_active(cable_not_active));
   task complete_run;
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t read %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_pin(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t pins %b exp %b", $time, got, exp);
      end
   endtask
   function logic [31:0] rd_exp(input logic [7:0] ad);
      case (ad[7:2])
         6'h3B: rd_exp = {24'h000000, phy_m & 8'h9C};
         6'h3C: rd_exp = {16'h0000, misc_m};
         default: rd_exp = 32'h00000000;
      endcase
   endfunction
   // Called at a falling edge; leaves the request up so accesses can run back to back
   task acc(input logic w, input logic [7:0] ad, input logic [3:0] be, input logic [31:0] dt);
      logic [31:0] e;
      e = rd_exp(ad);
      cfg_req = '{w, !w, ad, be, dt};
      @(negedge clk_sys);
      if (w && ad[7:2] == 6'h3B && be[0]) phy_m = (phy_m & 8'h60) | (dt[7:0] & 8'h9F);
      if (w && ad[7:2] == 6'h3C && be[0]) misc_m[7:0] = (misc_m[7:0] & 8'hE0) | (dt[7:0] & 8'h1F);
      if (w && ad[7:2] == 6'h3C && be[1])
         misc_m[15:8] = (misc_m[15:8] & 8'h50) | (dt[15:8] & 8'hAF);
      cmp_pin({3'b000, cfg_rsp.ack}, 4'h1);
      if (!w) cmp_reg(cfg_rsp.rdata, e);
   endtask
   task idle(input int n);
      cfg_req.wr = 0;
      cfg_req.rd = 0;
      repeat (n) @(negedge clk_sys);
   endtask
   // Pins settle through the two-stage synchroniser plus the output register
   task pins;
      idle(5);
      cmp_pin({cable_activity_out, phy_reset_ctl, phy_powerdown_ctl, ultra_low_power},
         {phy_m[7] & (cable_idle_set | phy_m[4] | phy_m[2]), phy_m[4], phy_m[2],
         phy_m[2] & ~link_power_status});
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         complete_run;
      end
   end
   initial begin
      repeat (2) @(negedge clk_sys);
      rst_n = 1;
      global_reset_n = 1;
      phy_m = 8'h08;
      misc_m = 16'h0810;
      acc(0, 8'hEC, 4'h0, 0);
      acc(0, 8'hF0, 4'h0, 0);
      pins;
      acc(1, 8'hEC, 4'hF, '1);
      acc(0, 8'hEC, 4'h0, 0);
      acc(1, 8'hF0, 4'hF, '1);
      acc(0, 8'hF0, 4'h0, 0);
      acc(1, 8'hE8, 4'hF, '1);
      acc(0, 8'hE8, 4'h0, 0);
      pins;
      for (i = 0; i < 60; i++) begin
         r = $random(seed);
         d = $random(seed);
         cable_idle_set = r[8];
         link_power_status = r[9];
         a = r[1] ? 8'hEC : (r[0] ? 8'hF0 : 8'hF4);
         acc(r[2], a, r[7:4], d);
         if (i % 8 == 7) pins;
      end
      // Power-down, release with a PHY reset pulse, then normal running
      acc(1, 8'hEC, 4'h1, 32'h0000008C);
      pins;
      acc(1, 8'hEC, 4'h1, 32'h00000098);
      pins;
      acc(1, 8'hEC, 4'h1, 32'h00000088);
      pins;
      // EEPROM load and a write in one cycle: the loaded bits win
      r = $random(seed);
      eeprom_phy_bits = r[15:8];
      eeprom_load = 1;
      acc(1, 8'hEC, 4'h1, r);
      eeprom_load = 0;
      phy_m = (phy_m & 8'h74) | (r[15:8] & 8'h8B);
      acc(0, 8'hEC, 4'h0, 0);
      pins;
      rst_n = 0;
      idle(2);
      // A write during the function reset is refused and leaves no trace
      cfg_req = '{1'b1, 1'b0, 8'hEC, 4'hF, 32'hFFFFFFFF};
      @(negedge clk_sys);
      cmp_pin({3'b000, cfg_rsp.ack}, 4'h0);
      r = $random(seed);
      eeprom_phy_bits = r[7:0];
      eeprom_load = 1;
      @(negedge clk_sys);
      eeprom_load = 0;
      phy_m = (phy_m & 8'h74) | (r[7:0] & 8'h8B);
      misc_m = misc_m & 16'hDFF8;
      idle(1);
      rst_n = 1;
      acc(0, 8'hEC, 4'h0, 0);
      acc(0, 8'hF0, 4'h0, 0);
      pins;
      global_reset_n = 0;
      idle(2);
      global_reset_n = 1;
      phy_m = 8'h08;
      misc_m = 16'h0810;
      acc(0, 8'hEC, 4'h0, 0);
      acc(0, 8'hF0, 4'h0, 0);
      pins;
      complete_run;
   end
endmodule
`default_nettype wire
